// [hdl/hbgp_pkg.sv]
// Shared constants for the host bus general purpose I/O port.
package hbgp_pkg;

  localparam int PIN_COUNT = 4;
  localparam int PIN_LSB = 4;
  localparam int CFG_IDX_W = 2;

  localparam logic [7:0] DATA_OFFSET = 8'h02;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] RESERVED_READ = 4'h0;

  localparam int DIR_BIT = 0;
  localparam int POL_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h1;
  localparam logic [5:0] CFG_UPPER_READ = 6'h00;
  localparam logic DATA_RESET = 1'b0;

  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT = 1'b1;

endpackage

// [hdl/hbgp_pin.sv]
// One port pin: control register, data bit, input synchroniser and output drive.
module hbgp_pin
  import hbgp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_raw_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic wr_bit_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_o,
  output logic data_o,
  output logic read_bit_o,
  output logic level_o,
  output logic pin_out_o,
  output logic pin_oe_o
);

  logic sync1_q;
  logic sync2_q;
  logic [1:0] cfg_q;
  logic data_q;
  logic data_d;
  logic dir;
  logic pol;

  ////////////////////////////////////////////////////////////////////////////
  // The pin is asynchronous to the host clock, so it is brought in through two flops.
  always_ff @(posedge ref_clk_i) begin
    sync1_q <= pin_raw_i;
    sync2_q <= sync1_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cfg_q <= CFG_RESET;
    end else if (cfg_wr_i) begin
      cfg_q <= cfg_wdata_i[1:0];
    end
  end

  assign dir = cfg_q[DIR_BIT];
  assign pol = cfg_q[POL_BIT];
  assign cfg_o = {CFG_UPPER_READ, cfg_q};

  ////////////////////////////////////////////////////////////////////////////
  assign level_o = sync2_q ^ pol;
  assign read_bit_o = (dir == DIR_INPUT) ? level_o : data_q;

  // The bit only moves on a host access; between accesses the pin may change freely.
  assign data_d = (data_wr_i && dir == DIR_OUTPUT) ? wr_bit_i :
                  (data_rd_i && dir == DIR_INPUT) ? level_o : data_q;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      data_q <= DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_o = data_q;
  assign pin_out_o = data_q ^ pol;
  assign pin_oe_o = (dir == DIR_OUTPUT);

endmodule

// [hdl/hbgp_port.sv]
// Four-pin general purpose port reached through the host runtime and configuration accesses.

// Operation
// - Four pins on data bits 4 to 7.
// - Data register decoded at runtime offset 02.
// - Each pin owns an 8-bit control register.
// - Control bit 0: 0 output, 1 input.
// - Control bit 1 inverts input and output.
// - Output pins drive high and low actively.
// - Input data bit takes the pin level only on reads.
// - Read captures input level, polarity applied.
// - Writes to input bits change nothing.
// - Output bit stored on write, driven out.
// - Output bit reads back last written value.
// - Data changes only on host accesses.
module hbgp_port
  import hbgp_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [CFG_IDX_W-1:0] cfg_idx_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Runtime access decode. A write in the same cycle as a read wins and the read is dropped.
  logic data_hit;
  logic data_wr;
  logic data_rd;
  logic host_rd_any;
  logic cfg_rd_any;
  logic [7:0] host_rdata_d;
  logic [7:0] host_rdata_q;
  logic host_rvalid_q;
  logic [7:0] cfg_rdata_q;
  logic cfg_rvalid_q;

  logic [NUM_PINS-1:0] pin_data;
  logic [NUM_PINS-1:0] pin_read;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_dir;
  logic [NUM_PINS-1:0] pin_pol;
  logic [NUM_PINS-1:0] cfg_sel;
  logic [7:0] cfg_all [NUM_PINS];

  assign data_hit = (host_addr_i == DATA_OFFSET);
  assign data_wr = host_wr_i && data_hit;
  assign host_rd_any = host_rd_i && !host_wr_i;
  assign data_rd = host_rd_any && data_hit;
  assign cfg_rd_any = cfg_rd_i && !cfg_wr_i;

  // Bits 0 to 3 hold no pins and always read as zero.
  assign host_rdata_d = data_hit ? {pin_read, RESERVED_READ} : UNMAPPED_READ;

  ////////////////////////////////////////////////////////////////////////////
  // One cell per pin; the pins share nothing but the decoded strobes.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign cfg_sel[i] = cfg_wr_i && (cfg_idx_i == CFG_IDX_W'(i));
    assign pin_dir[i] = cfg_all[i][DIR_BIT];
    assign pin_pol[i] = cfg_all[i][POL_BIT];

    hbgp_pin u_pin (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .pin_raw_i(pin_in_i[i]),
      .data_wr_i(data_wr),
      .data_rd_i(data_rd),
      .wr_bit_i(host_wdata_i[PIN_LSB+i]),
      .cfg_wr_i(cfg_sel[i]),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_o(cfg_all[i]),
      .data_o(pin_data[i]),
      .read_bit_o(pin_read[i]),
      .level_o(pin_level[i]),
      .pin_out_o(pin_out_o[i]),
      .pin_oe_o(pin_oe_o[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers are registered, so each read is answered one cycle after it is taken.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      host_rdata_q <= UNMAPPED_READ;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= host_rd_any;
      if (host_rd_any) begin
        host_rdata_q <= host_rdata_d;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cfg_rdata_q <= UNMAPPED_READ;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd_any;
      if (cfg_rd_any) begin
        cfg_rdata_q <= cfg_all[cfg_idx_i];
      end
    end
  end

  assign host_rdata_o = host_rdata_q;
  assign host_rvalid_o = host_rvalid_q;
  assign cfg_rdata_o = cfg_rdata_q;
  assign cfg_rvalid_o = cfg_rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the port behaviour.
  property p_push_pull;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pin_oe_o == ~pin_dir;
  endproperty
  a_push_pull_drive: assert property (p_push_pull)
    else $error("Output enable does not follow direction.");

  property p_out_value;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (pin_out_o & ~pin_dir) == ((pin_data ^ pin_pol) & ~pin_dir);
  endproperty
  a_out_pin_value: assert property (p_out_value)
    else $error("Output pin level differs from stored bit and polarity.");

  property p_read_frame;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      data_rd |=> host_rvalid_o && host_rdata_o[PIN_LSB-1:0] == RESERVED_READ;
  endproperty
  a_read_reserved_zero: assert property (p_read_frame)
    else $error("Reserved data bits not zero or no read answer.");

  property p_wr_input;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      data_wr |=> (pin_data & $past(pin_dir)) == ($past(pin_data) & $past(pin_dir));
  endproperty
  a_write_input_ignored: assert property (p_wr_input)
    else $error("Write changed a bit of an input pin.");

  property p_wr_output;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (data_wr && cfg_sel == '0) |=>
        (pin_data & ~pin_dir) == ($past(host_wdata_i[PIN_LSB+:NUM_PINS]) & ~pin_dir);
  endproperty
  a_write_output_store: assert property (p_wr_output)
    else $error("Write did not store the output bits.");

  property p_idle_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!data_wr && !data_rd) |=> $stable(pin_data);
  endproperty
  a_data_idle_hold: assert property (p_idle_hold)
    else $error("Data bits changed without a data register access.");

  property p_rd_output;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      data_rd |=> (host_rdata_o[PIN_LSB+:NUM_PINS] & ~$past(pin_dir)) ==
                  ($past(pin_data) & ~$past(pin_dir));
  endproperty
  a_read_output_last: assert property (p_rd_output)
    else $error("Output bit read back is not the last written value.");

  property p_rd_input;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      data_rd |=> (host_rdata_o[PIN_LSB+:NUM_PINS] & $past(pin_dir)) ==
                  ($past(pin_level) & $past(pin_dir)) &&
                  (pin_data & $past(pin_dir)) == ($past(pin_level) & $past(pin_dir));
  endproperty
  a_read_input_capture: assert property (p_rd_input)
    else $error("Input read did not capture the pin level.");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (host_rd_any && !data_hit) |=> host_rvalid_o && host_rdata_o == UNMAPPED_READ;
  endproperty
  a_read_unmapped_zero: assert property (p_unmapped)
    else $error("Unmapped runtime read did not return zero.");

  property p_reset_clear;
    @(posedge ref_clk_i)
      !reset_n_i |=> pin_data == '0 && pin_dir == '1;
  endproperty
  a_reset_data_clear: assert property (p_reset_clear)
    else $error("Reset did not clear the data bits.");

  property p_cfg_write;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (cfg_wr_i ##1 cfg_rd_any && !cfg_wr_i && cfg_idx_i == $past(cfg_idx_i)) |=>
        cfg_rdata_o == {CFG_UPPER_READ, $past(cfg_wdata_i[1:0], 2)};
  endproperty
  a_cfg_write_readback: assert property (p_cfg_write)
    else $error("Control register readback differs from the written value.");

  property p_rd_taken;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      host_rd_any |=> host_rvalid_o;
  endproperty
  a_read_answer_taken: assert property (p_rd_taken)
    else $error("Taken runtime read was not answered.");

  property p_rd_none;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !host_rd_any |=> !host_rvalid_o;
  endproperty
  a_read_answer_none: assert property (p_rd_none)
    else $error("Runtime read answer without a taken read.");

  property p_rd_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !host_rd_any |=> $stable(host_rdata_o);
  endproperty
  a_read_data_hold: assert property (p_rd_hold)
    else $error("Runtime read data changed without a read.");

  property p_cfg_taken;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_rd_any |=> cfg_rvalid_o;
  endproperty
  a_cfg_answer_taken: assert property (p_cfg_taken)
    else $error("Taken control read was not answered.");

  property p_cfg_none;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !cfg_rd_any |=> !cfg_rvalid_o;
  endproperty
  a_cfg_answer_none: assert property (p_cfg_none)
    else $error("Control read answer without a taken read.");

  property p_cfg_upper;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_rvalid_o |-> cfg_rdata_o[7:2] == CFG_UPPER_READ;
  endproperty
  a_cfg_upper_zero: assert property (p_cfg_upper)
    else $error("Unused control bits did not read as zero.");

  property p_cfg_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !cfg_rd_any |=> $stable(cfg_rdata_o);
  endproperty
  a_cfg_data_hold: assert property (p_cfg_hold)
    else $error("Control read data changed without a read.");

  property p_cfg_only;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !cfg_wr_i |=> $stable(pin_dir) && $stable(pin_pol);
  endproperty
  a_cfg_write_only: assert property (p_cfg_only)
    else $error("Direction or polarity changed without a control write.");

  property p_cfg_apply;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_wr_i |=> pin_dir[$past(cfg_idx_i)] == $past(cfg_wdata_i[DIR_BIT]) &&
                   pin_pol[$past(cfg_idx_i)] == $past(cfg_wdata_i[POL_BIT]);
  endproperty
  a_cfg_write_applies: assert property (p_cfg_apply)
    else $error("Control write did not set direction and polarity.");

  property p_reset_pins;
    @(posedge ref_clk_i)
      !reset_n_i |=> pin_oe_o == '0 && pin_out_o == '0;
  endproperty
  a_reset_pins_quiet: assert property (p_reset_pins)
    else $error("Pins driven or output level not low after reset.");

  property p_rd_keeps;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      data_rd |=> (pin_data & ~$past(pin_dir)) == ($past(pin_data) & ~$past(pin_dir));
  endproperty
  a_read_output_keeps: assert property (p_rd_keeps)
    else $error("Read changed a stored output bit.");

  property p_other_wr;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (host_wr_i && !data_hit) |=> $stable(pin_data);
  endproperty
  a_unmapped_write_ignored: assert property (p_other_wr)
    else $error("Write to another offset changed the data bits.");

  property p_level_sync;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pin_level == ($past(pin_in_i, 2) ^ pin_pol);
  endproperty
  a_input_level_sync: assert property (p_level_sync)
    else $error("Input level does not follow the synchronised pin.");

  c_read_input: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    data_rd && pin_dir != '0 ##1 host_rvalid_o);
  c_write_output: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    data_wr && pin_dir != '1);
  c_inverted_output: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (pin_pol & ~pin_dir) != '0 && pin_oe_o != '0);
  c_unmapped_read: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    host_rd_any && !data_hit);
  c_cfg_back_to_back: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cfg_wr_i ##1 cfg_rd_any);

endmodule

// [bench/hbgp_pin_env.sv]
// Pin-side environment model: resolves each pin from the port drive and an outside level.
module hbgp_pin_env (
  input wire logic [3:0] ext_level_i,
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_oe_i,
  output logic [3:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The outside driver yields wherever the port drives, so an output pin shows the port's value.
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);
endmodule

// [bench/hbgp_port_tb.sv]
// Self-checking testbench for the host bus general purpose port.
module hbgp_port_tb;
  import hbgp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic host_rd_i = 1'b0;
  logic host_wr_i = 1'b0;
  logic [7:0] host_addr_i = 8'h00;
  logic [7:0] host_wdata_i = 8'h00;
  logic cfg_rd_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [CFG_IDX_W-1:0] cfg_idx_i = '0;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic [3:0] ext_level = 4'hF;
  logic [7:0] host_rdata_o, cfg_rdata_o;
  logic host_rvalid_o, cfg_rvalid_o;
  logic [3:0] pin_in_i, pin_out_o, pin_oe_o;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] d;

  always #12.5 ref_clk_i = ~ref_clk_i;

  hbgp_port #(.NUM_PINS(4)) uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .host_rd_i(host_rd_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

  hbgp_pin_env env (.ext_level_i(ext_level), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .pin_level_o(pin_in_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic host_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= v;
    @(posedge ref_clk_i);
    host_wr_i <= 1'b0;
    #1;
  endtask

  task automatic host_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge ref_clk_i);
    host_rd_i <= 1'b0;
    #1;
    check("host_rvalid", {7'h00, host_rvalid_o}, 8'h01);
    v = host_rdata_o;
  endtask

  task automatic cfg_wr(input int i, input logic [7:0] v);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_idx_i <= CFG_IDX_W'(i);
    cfg_wdata_i <= v;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic cfg_rd(input int i, output logic [7:0] v);
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_idx_i <= CFG_IDX_W'(i);
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    check("cfg_rvalid", {7'h00, cfg_rvalid_o}, 8'h01);
    v = cfg_rdata_o;
  endtask

  task automatic cfg_wr_rd(input int i, input logic [7:0] v, output logic [7:0] r);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_idx_i <= CFG_IDX_W'(i);
    cfg_wdata_i <= v;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    check("cfg_b2b_rvalid", {7'h00, cfg_rvalid_o}, 8'h01);
    r = cfg_rdata_o;
  endtask

  task automatic set_all(input logic [7:0] v);
    for (int i = 0; i < 4; i++) cfg_wr(i, v);
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      cfg_rd(i, d);
      check("cfg_reset", d, 8'h01);
    end
    check("oe_reset", {4'h0, pin_oe_o}, 8'h00);
    set_all(8'h00);
    check("out_after_reset", {4'h0, pin_out_o}, 8'h00);
    host_rd(DATA_OFFSET, d);
    check("read_after_reset", d, 8'h00);
  endtask

  task automatic t_input();
    for (int p = 0; p < 2; p++) begin
      set_all(p ? 8'h03 : 8'h01);
      ext_level = 4'h6;
      settle();
      host_rd(DATA_OFFSET, d);
      check("input_read", d, {p ? 4'h9 : 4'h6, 4'h0});
    end
  endtask

  task automatic t_capture();
    // The data bit is captured at the read only, so a later pin change must not reach it.
    set_all(8'h01);
    ext_level = 4'h5;
    settle();
    host_rd(DATA_OFFSET, d);
    check("capture_read", d, 8'h50);
    ext_level = 4'hA;
    settle();
    host_wr(DATA_OFFSET, 8'hF0);
    set_all(8'h00);
    check("write_to_input", {4'h0, pin_out_o}, 8'h05);
  endtask

  task automatic t_output();
    ext_level = 4'h5;
    host_wr(DATA_OFFSET, 8'hA3);
    check("out_drive", {4'h0, pin_out_o}, 8'h0A);
    check("out_enable", {4'h0, pin_oe_o}, 8'h0F);
    host_rd(DATA_OFFSET, d);
    check("out_readback", d, 8'hA0);
    set_all(8'h02);
    check("out_inverted", {4'h0, pin_out_o}, 8'h05);
    host_rd(DATA_OFFSET, d);
    check("inv_readback", d, 8'hA0);
  endtask

  task automatic t_offset();
    host_wr(8'h03, 8'h00);
    check("other_wr", {4'h0, pin_out_o}, 8'h05);
    host_rd(8'h03, d);
    check("other_rd", d, UNMAPPED_READ);
  endtask

  task automatic t_cfg();
    cfg_wr(2, 8'hFD);
    cfg_rd(2, d);
    check("cfg_upper", d, 8'h01);
    check("cfg_per_pin", {4'h0, pin_oe_o}, 8'h0B);
    cfg_wr_rd(1, 8'hFC, d);
    check("cfg_b2b", d, 8'h00);
    check("cfg_b2b_drive", {4'h0, pin_out_o}, 8'h03);
  endtask

  task automatic t_midreset();
    // Stored output bits must not survive a reset in mid-run.
    set_all(8'h00);
    host_wr(DATA_OFFSET, 8'hF0);
    check("out_before_reset", {4'h0, pin_out_o}, 8'h0F);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    #1;
    check("oe_mid_reset", {4'h0, pin_oe_o}, 8'h00);
    settle();
    set_all(8'h00);
    check("out_mid_reset", {4'h0, pin_out_o}, 8'h00);
    host_rd(DATA_OFFSET, d);
    check("read_mid_reset", d, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #(25ns * 3000);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    settle();
    t_reset();
    t_input();
    t_capture();
    t_output();
    t_offset();
    t_cfg();
    t_midreset();
    print_verdict();
  end
endmodule
